// ===== core/prvl_rom_front.sv
// Top of the program-memory vector fetch and lookup-table service.
`include "prvl_consts.svh"
module prvl_rom_front #(
  parameter int ROM_DEPTH = `PRVL_ROM_DEPTH
) (
  input  wire logic                 clk_sys_in,
  input  wire logic                 sys_rst_in,
  input  wire logic                 irq_req_in,
  input  wire prvl_pkg::prvl_src_e  irq_src_in,
  input  wire logic                 ref_req_in,
  input  wire logic [5:0]           ref_index_in,
  input  wire logic [7:0]           dm_addr_in,
  input  wire logic                 dm_indirect_in,
  input  wire logic [3:0]           bank_sel_in,
  input  wire prvl_pkg::prvl_byte_t rom_data_in,
  output prvl_pkg::prvl_addr_t      rom_addr_out,
  output logic                      rom_rd_out,
  output prvl_pkg::prvl_addr_t      pc_out,
  output logic                      mem_bank_enable_flag_out,
  output logic                      register_bank_enable_flag_out,
  output logic                      busy_out,
  output logic                      vec_done_out,
  output logic                      lut_valid_out,
  output prvl_pkg::prvl_byte_t      lut_first_out,
  output prvl_pkg::prvl_byte_t      lut_second_out,
  output logic                      table_jump_form_out,
  output logic                      table_call_form_out,
  output logic                      ref_err_out,
  output logic [3:0]                dm_bank_out
);
  import prvl_pkg::*;

  // The counter must span exactly the whole program space.
  if (ROM_DEPTH != (1 << `PRVL_PC_W)) begin : g_depth_check
    $error("ROM_DEPTH must equal the 13-bit program space");
  end

  prvl_state_e st_ff;
  prvl_state_e nxt_st;
  prvl_addr_t  rd_base;
  prvl_byte_t  rd_first;
  prvl_byte_t  rd_second;
  logic        rd_done;
  logic        rd_start;
  logic        irq_take;
  logic        ref_take;
  logic        ref_bad;
  logic        vec_fin;
  logic        ref_fin;
  logic        is_jump;
  logic        is_call;
  prvl_addr_t  entry_target;
  logic [3:0]  nxt_bank;

  ////////////////////////////////////////////////////////////////////////////
  // Slot address of a vector source: two bytes per slot from the base.
  function automatic prvl_addr_t slot_addr(input prvl_src_e src);
    slot_addr = `PRVL_VEC_BASE | {9'h000, src, 1'b0};
  endfunction

  // Interrupt sources with a defined slot; reset is left to boot, slot 8 and the code 7 carry no vector.
  function automatic logic src_valid(input prvl_src_e src);
    src_valid = (src != PRVL_SRC_UNUSED) && (src != PRVL_SRC_NONE) &&
                (src != PRVL_SRC_RESET);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request acceptance. Reset's vector is fetched only by the boot state,
  // an interrupt wins over a lookup offered in the same idle cycle.
  assign irq_take = (st_ff == PRVL_ST_IDLE) && irq_req_in &&
                    src_valid(irq_src_in);
  assign ref_bad  = ref_index_in < `PRVL_REF_MIN_IDX;
  assign ref_take = (st_ff == PRVL_ST_IDLE) && !irq_take && ref_req_in &&
                    !ref_bad;
  assign rd_start = (st_ff == PRVL_ST_BOOT) || irq_take || ref_take;

  // Entry address is twice the index, so always even and in the table.
  assign rd_base = (st_ff == PRVL_ST_BOOT) ? `PRVL_VEC_BASE :
                   irq_take ? slot_addr(irq_src_in) :
                   {6'h00, ref_index_in, 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Decoding of a finished transfer.
  assign vec_fin = rd_done && (st_ff == PRVL_ST_VEC);
  assign ref_fin = rd_done && (st_ff == PRVL_ST_REF);
  assign is_jump = rd_first[7:5] == `PRVL_TBL_JUMP_TAG;
  assign is_call = rd_first[7:5] == `PRVL_TBL_CALL_TAG;
  // Both the vector and the branch forms carry a full 13-bit address, so
  // any location, plain storage included, can be a target.
  assign entry_target = {rd_first[4:0], rd_second};

  // Memory flag off confines direct access to bank 0 low half and bank 15,
  // indirect access to bank 0; on, the selected bank is used.
  assign nxt_bank = mem_bank_enable_flag_out ? bank_sel_in :
                    dm_indirect_in ? `PRVL_BANK_ZERO :
                    dm_addr_in[7] ? `PRVL_BANK_PERIPH : `PRVL_BANK_ZERO;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      PRVL_ST_BOOT: nxt_st = PRVL_ST_VEC;
      PRVL_ST_IDLE: begin
        if (irq_take) begin
          nxt_st = PRVL_ST_VEC;
        end else if (ref_take) begin
          nxt_st = PRVL_ST_REF;
        end
      end
      PRVL_ST_VEC:  nxt_st = rd_done ? PRVL_ST_IDLE : PRVL_ST_VEC;
      PRVL_ST_REF:  nxt_st = rd_done ? PRVL_ST_IDLE : PRVL_ST_REF;
      default:      nxt_st = PRVL_ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reader of the two-byte vector or table entry.
  prvl_pair_reader u_reader (
    .clk_sys_in   (clk_sys_in),
    .sys_rst_in   (sys_rst_in),
    .start_in     (rd_start),
    .base_in      (rd_base),
    .rom_data_in  (rom_data_in),
    .rom_addr_out (rom_addr_out),
    .rom_rd_out   (rom_rd_out),
    .first_out    (rd_first),
    .second_out   (rd_second),
    .done_out     (rd_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state and one-cycle pulses.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_ff               <= PRVL_ST_BOOT;
      busy_out            <= 1'b1;
      vec_done_out        <= 1'b0;
      lut_valid_out       <= 1'b0;
      table_jump_form_out <= 1'b0;
      table_call_form_out <= 1'b0;
      ref_err_out         <= 1'b0;
    end else begin
      st_ff               <= nxt_st;
      busy_out            <= nxt_st != PRVL_ST_IDLE;
      vec_done_out        <= vec_fin;
      lut_valid_out       <= ref_fin && !is_jump && !is_call;
      table_jump_form_out <= ref_fin && is_jump;
      table_call_form_out <= ref_fin && is_call;
      ref_err_out         <= (st_ff == PRVL_ST_IDLE) && !irq_take &&
                             ref_req_in && ref_bad;
    end
  end

  // Flags and counter load together from the vector; the zero bit is not
  // checked, a stray one there is simply ignored.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pc_out                        <= `PRVL_VEC_BASE;
      mem_bank_enable_flag_out      <= `PRVL_RST_MEM_FLAG;
      register_bank_enable_flag_out <= `PRVL_RST_REG_FLAG;
    end else if (vec_fin) begin
      mem_bank_enable_flag_out      <= rd_first[`PRVL_MEM_FLAG_BIT];
      register_bank_enable_flag_out <= rd_first[`PRVL_REG_FLAG_BIT];
      pc_out                        <= entry_target;
    end else if (ref_fin && (is_jump || is_call)) begin
      pc_out <= entry_target;
    end
  end

  // Plain entries hand both bytes to the core in place of the opcode.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      lut_first_out  <= 8'h00;
      lut_second_out <= 8'h00;
      dm_bank_out    <= `PRVL_BANK_ZERO;
    end else begin
      if (ref_fin) begin
        lut_first_out  <= rd_first;
        lut_second_out <= rd_second;
      end
      dm_bank_out <= nxt_bank;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the sequencing.
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_pair_reads;
    rom_rd_out ##1 (rom_rd_out && rom_addr_out == $past(rom_addr_out) + 13'h1)
    ##1 !rom_rd_out;
  endsequence

  a_boot_vector_zero: assert property (
    (st_ff == PRVL_ST_BOOT) |=> rom_rd_out && rom_addr_out == `PRVL_VEC_BASE)
    else $error("boot vector not fetched from slot zero");

  a_irq_own_slot: assert property (
    irq_take |=> rom_rd_out &&
                 rom_addr_out == {9'h000, $past(irq_src_in), 1'b0} &&
                 rom_addr_out <= `PRVL_VEC_LAST)
    else $error("interrupt vector read from wrong slot");

  a_vec_load_pc: assert property (
    vec_fin |=> vec_done_out && pc_out == $past(entry_target))
    else $error("counter not loaded from vector");

  a_vec_load_flags: assert property (
    vec_fin |=> mem_bank_enable_flag_out == $past(rd_first[7]) &&
                register_bank_enable_flag_out == $past(rd_first[6]))
    else $error("bank flags not loaded from vector");

  a_ref_entry_addr: assert property (
    ref_take |=> rom_addr_out == {6'h00, $past(ref_index_in), 1'b0} &&
                 !rom_addr_out[0])
    else $error("table entry address not twice the index");

  a_ref_in_table: assert property (
    (st_ff == PRVL_ST_REF && rom_rd_out) |->
      rom_addr_out >= `PRVL_REF_BASE && rom_addr_out <= `PRVL_REF_LAST)
    else $error("lookup read outside the table");

  a_ref_pair_done: assert property (
    ref_take |=> s_pair_reads ##2
      (lut_valid_out ^ table_jump_form_out ^ table_call_form_out))
    else $error("table entry not read as a byte pair");

  a_branch_target: assert property (
    (ref_fin && (is_jump || is_call)) |=> pc_out == $past(entry_target) &&
      !lut_valid_out)
    else $error("table branch target not taken");

  a_bank_restrict: assert property (
    (!mem_bank_enable_flag_out && dm_indirect_in) |=>
      dm_bank_out == `PRVL_BANK_ZERO)
    else $error("indirect access left bank zero with flag off");
endmodule // prvl_rom_front

// ===== core/prvl_consts.svh
// Constants of the program-memory vector and lookup front end.
// Overview of operation
// - 8192 program bytes, all reached by the 13-bit counter, no banking.
// - Locations 0000H to 000FH hold the reset and interrupt vectors.
// - Vector byte one: memory flag, register flag, zero, counter bits 12-8.
// - Taking reset or interrupt loads both flags and the start address at once.
// - Slots: reset 0, irq b 2, irq 0 4, irq 1 6, timers A and C.
// - Each interrupt fetches its vector only from its own slot address.
// - 0010H-001FH and 0080H-1FFFH are plain program storage.
// - Lookup opcode is served from the 96-byte table at 0020H-007FH.
// - A table entry runs as one two-byte or two one-byte instructions.
// - Table entries start on even addresses; indexing steps by two bytes.
// - Table jump or call reaches any program address held in the entry.
// - Memory flag zero limits data banks to 0 and 15; one uses selection.
`ifndef PRVL_CONSTS_SVH
`define PRVL_CONSTS_SVH

`define PRVL_ROM_DEPTH    8192
`define PRVL_PC_W         13
`define PRVL_VEC_BASE     13'h0000
`define PRVL_VEC_LAST     13'h000f
`define PRVL_GP_LOW_BASE  13'h0010
`define PRVL_REF_BASE     13'h0020
`define PRVL_REF_LAST     13'h007f
`define PRVL_GP_HIGH_BASE 13'h0080
`define PRVL_REF_MIN_IDX  6'h10
`define PRVL_MEM_FLAG_BIT 7
`define PRVL_REG_FLAG_BIT 6
`define PRVL_ZERO_BIT     5
`define PRVL_TBL_JUMP_TAG 3'h2
`define PRVL_TBL_CALL_TAG 3'h3
`define PRVL_RST_MEM_FLAG 1'b0
`define PRVL_RST_REG_FLAG 1'b0
`define PRVL_BANK_ZERO    4'h0
`define PRVL_BANK_PERIPH  4'hf

`endif

// ===== core/prvl_pkg.sv
// Types shared by the program-memory vector and lookup front end.
package prvl_pkg;
  typedef logic [12:0] prvl_addr_t;
  typedef logic [7:0]  prvl_byte_t;

  // Vector sources; the code times two is the slot address.
  typedef enum logic [2:0] {
    PRVL_SRC_RESET  = 3'b000,
    PRVL_SRC_IRQ_B  = 3'b001,
    PRVL_SRC_IRQ_Z  = 3'b010,
    PRVL_SRC_IRQ_O  = 3'b011,
    PRVL_SRC_UNUSED = 3'b100,
    PRVL_SRC_TMR_Z  = 3'b101,
    PRVL_SRC_TMR_O  = 3'b110,
    PRVL_SRC_NONE   = 3'b111
  } prvl_src_e;

  typedef enum logic [1:0] {
    PRVL_ST_BOOT = 2'b00,
    PRVL_ST_IDLE = 2'b01,
    PRVL_ST_VEC  = 2'b10,
    PRVL_ST_REF  = 2'b11
  } prvl_state_e;

  typedef enum logic [1:0] {
    PRVL_RD_IDLE   = 2'b00,
    PRVL_RD_FIRST  = 2'b01,
    PRVL_RD_SECOND = 2'b10,
    PRVL_RD_LAST   = 2'b11
  } prvl_rd_state_e;
endpackage

// ===== core/prvl_pair_reader.sv
// Two-byte reader from an even program address of the synchronous ROM.
`include "prvl_consts.svh"
module prvl_pair_reader (
  input  wire logic               clk_sys_in,
  input  wire logic               sys_rst_in,
  input  wire logic               start_in,
  input  wire prvl_pkg::prvl_addr_t base_in,
  input  wire prvl_pkg::prvl_byte_t rom_data_in,
  output prvl_pkg::prvl_addr_t    rom_addr_out,
  output logic                    rom_rd_out,
  output prvl_pkg::prvl_byte_t    first_out,
  output prvl_pkg::prvl_byte_t    second_out,
  output logic                    done_out
);
  import prvl_pkg::*;

  prvl_rd_state_e st_ff;
  prvl_rd_state_e nxt_st;
  logic           take;

  ////////////////////////////////////////////////////////////////////////////
  // A start is only taken while idle; the caller gates it on its own state.
  assign take = start_in && (st_ff == PRVL_RD_IDLE);

  // ROM data arrives one cycle after the read strobe.
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      PRVL_RD_IDLE:   nxt_st = take ? PRVL_RD_FIRST : PRVL_RD_IDLE;
      PRVL_RD_FIRST:  nxt_st = PRVL_RD_SECOND;
      PRVL_RD_SECOND: nxt_st = PRVL_RD_LAST;
      PRVL_RD_LAST:   nxt_st = PRVL_RD_IDLE;
      default:        nxt_st = PRVL_RD_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State and strobe registers.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_ff        <= PRVL_RD_IDLE;
      rom_rd_out   <= 1'b0;
      rom_addr_out <= `PRVL_VEC_BASE;
      done_out     <= 1'b0;
    end else begin
      st_ff      <= nxt_st;
      rom_rd_out <= take || (st_ff == PRVL_RD_FIRST);
      done_out   <= (st_ff == PRVL_RD_LAST);
      if (take) begin
        rom_addr_out <= base_in;
      end else if (st_ff == PRVL_RD_FIRST) begin
        rom_addr_out <= rom_addr_out + 13'h0001; // Second byte follows.
      end
    end
  end

  // Captured bytes hold until the next transfer.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      first_out  <= 8'h00;
      second_out <= 8'h00;
    end else begin
      if (st_ff == PRVL_RD_SECOND) begin
        first_out <= rom_data_in;
      end
      if (st_ff == PRVL_RD_LAST) begin
        second_out <= rom_data_in;
      end
    end
  end
endmodule // prvl_pair_reader

// ===== verif/prvl_rom_model.sv
// Behavioural model of the synchronous program ROM facing the front end.
module prvl_rom_model
  import prvl_pkg::*;
(
  input  wire logic                 clk_sys_in,
  input  wire logic                 rd_in,
  input  wire prvl_pkg::prvl_addr_t addr_in,
  output prvl_pkg::prvl_byte_t      data_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // Byte-wide store of 8192 locations, reached without banking.
  prvl_byte_t mem [0:8191];

  // One-cycle read latency; when no read is asked the bus flips its value.
  // The flipping keeps a stale byte from passing for a fresh one.
  always @(posedge clk_sys_in) begin
    if (rd_in) begin
      data_out <= mem[addr_in];
    end else begin
      data_out <= ~data_out;
    end
  end
endmodule // prvl_rom_model

// ===== verif/prvl_tb.sv
// Self-checking bench for the vector fetch and lookup-table front end.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import prvl_pkg::*;

  logic       clk_sys_in     = 1'b0;
  logic       sys_rst_in     = 1'b1;
  logic       irq_req_in     = 1'b0;
  prvl_src_e  irq_src_in     = PRVL_SRC_NONE;
  logic       ref_req_in     = 1'b0;
  logic [5:0] ref_index_in   = 6'h00;
  logic [7:0] dm_addr_in     = 8'h00;
  logic       dm_indirect_in = 1'b0;
  logic [3:0] bank_sel_in    = 4'h0;
  prvl_byte_t rom_data_in;
  prvl_addr_t rom_addr_out;
  prvl_addr_t pc_out;
  prvl_byte_t lf;
  prvl_byte_t ls;
  logic       rom_rd_out;
  logic       mflag;
  logic       rflag;
  logic       busy;
  logic       vdone;
  logic       lv;
  logic       tj;
  logic       tc;
  logic       rerr;
  logic [3:0] dm_bank;
  int         error_cnt = 0;
  int         tests_run = 0;
  prvl_addr_t exp_pc;
  prvl_src_e  srcs [5] = '{PRVL_SRC_IRQ_B, PRVL_SRC_IRQ_Z, PRVL_SRC_IRQ_O,
                           PRVL_SRC_TMR_Z, PRVL_SRC_TMR_O};

  // Clock of 8 ns period.
  always #4 clk_sys_in = ~clk_sys_in;

  prvl_rom_front dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .irq_req_in(irq_req_in), .irq_src_in(irq_src_in),
    .ref_req_in(ref_req_in), .ref_index_in(ref_index_in),
    .dm_addr_in(dm_addr_in), .dm_indirect_in(dm_indirect_in),
    .bank_sel_in(bank_sel_in), .rom_data_in(rom_data_in),
    .rom_addr_out(rom_addr_out), .rom_rd_out(rom_rd_out), .pc_out(pc_out),
    .mem_bank_enable_flag_out(mflag),
    .register_bank_enable_flag_out(rflag), .busy_out(busy),
    .vec_done_out(vdone), .lut_valid_out(lv), .lut_first_out(lf),
    .lut_second_out(ls), .table_jump_form_out(tj),
    .table_call_form_out(tc), .ref_err_out(rerr), .dm_bank_out(dm_bank));

  prvl_rom_model rom (.clk_sys_in(clk_sys_in), .rd_in(rom_rd_out),
    .addr_in(rom_addr_out), .data_out(rom_data_in));

  ////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Inputs move 1 ns after the edge, where outputs have also settled.
  task automatic tick;
    @(posedge clk_sys_in);
    #1;
  endtask

  // Counts cycles to the first answer pulse and notes the first ROM address.
  task automatic wait_pulse(output int n, output prvl_addr_t fa);
    logic got;
    got = 1'b0;
    n = 0;
    fa = 13'h1fff;
    for (int i = 1; i <= 12; i++) begin
      tick;
      irq_req_in = 1'b0;
      ref_req_in = 1'b0;
      if (rom_rd_out === 1'b1 && !got) begin
        fa = rom_addr_out;
        got = 1'b1;
      end
      if ((vdone | lv | tj | tc | rerr) === 1'b1) begin
        n = i;
        break;
      end
    end
  endtask

  // Effective data bank worked out from the flag and the access kind.
  function automatic logic [3:0] bank_of(logic f, logic ind, logic [7:0] a,
                                         logic [3:0] s);
    if (f) return s;
    if (ind) return 4'h0;
    return a[7] ? 4'hf : 4'h0;
  endfunction

  task automatic chk_bank;
    logic [3:0] eb;
    dm_addr_in = 8'($urandom);
    dm_indirect_in = 1'($urandom);
    bank_sel_in = 4'($urandom);
    tick;
    eb = bank_of(mflag, dm_indirect_in, dm_addr_in, bank_sel_in);
    chk(16'(dm_bank), 16'(eb));
  endtask

  // Slot address of each vector source, as the slot map fixes it.
  function automatic prvl_addr_t slot_of(prvl_src_e s);
    case (s)
      PRVL_SRC_IRQ_B: return 13'h0002;
      PRVL_SRC_IRQ_Z: return 13'h0004;
      PRVL_SRC_IRQ_O: return 13'h0006;
      PRVL_SRC_TMR_Z: return 13'h000a;
      PRVL_SRC_TMR_O: return 13'h000c;
      default:        return 13'h0000;
    endcase
  endfunction

  // Checks a loaded vector against the bytes stored at its slot.
  task automatic chk_vec(input prvl_addr_t slot, input int n, input int dly,
                         input prvl_addr_t fa);
    prvl_byte_t b0;
    prvl_byte_t b1;
    b0 = rom.mem[slot];
    b1 = rom.mem[slot + 13'h0001];
    exp_pc = {b0[4:0], b1};
    chk(16'(n), 16'(dly));
    chk(16'(fa), 16'(slot));
    chk(16'(pc_out), 16'(exp_pc));
    chk(16'({mflag, rflag}), 16'(b0[7:6]));
    chk(16'(busy), 16'h0000);
    chk_bank;
  endtask

  task automatic vec(input prvl_src_e s, input logic with_ref);
    int n;
    prvl_addr_t fa;
    irq_src_in = s;
    irq_req_in = 1'b1;
    ref_req_in = with_ref;
    ref_index_in = 6'h20;
    wait_pulse(n, fa);
    chk_vec(slot_of(s), n, 5, fa);
  endtask

  // Lookup entry of kind 0 plain, 1 table jump, 2 table call.
  task automatic lookup(input logic [5:0] idx, input int kind);
    int n;
    prvl_addr_t fa;
    prvl_addr_t a;
    prvl_byte_t b0;
    prvl_byte_t b1;
    a = {6'h00, idx, 1'b0};
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    if (kind == 0 && b0[7:6] == 2'b01) b0[7] = 1'b1;
    if (kind == 1) b0[7:5] = 3'h2;
    if (kind == 2) b0[7:5] = 3'h3;
    rom.mem[a] = b0;
    rom.mem[a + 13'h0001] = b1;
    ref_index_in = idx;
    ref_req_in = 1'b1;
    wait_pulse(n, fa);
    chk(16'(n), 16'h0005);
    chk(16'(fa), 16'(a));
    chk(16'({lv, tj, tc}), 16'(3'b100 >> kind));
    if (kind == 0) begin
      chk({lf, ls}, {b0, b1});
      chk(16'(pc_out), 16'(exp_pc));
    end else begin
      exp_pc = {b0[4:0], b1};
      chk(16'(pc_out), 16'(exp_pc));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: boot, every vector source, refusals, then the table.
  initial begin
    int n;
    prvl_addr_t fa;
    void'($urandom(70));
    for (int a = 0; a < 8192; a++) rom.mem[a] = 8'($urandom);
    repeat (20) tick;
    sys_rst_in = 1'b0;
    wait_pulse(n, fa);
    chk_vec(13'h0000, n, 5, fa);
    for (int r = 0; r < 4; r++) begin
      foreach (srcs[i]) vec(srcs[i], 1'($urandom));
    end
    foreach (srcs[i]) vec(srcs[i], 1'b1);
    for (int i = 0; i < 3; i++) begin
      irq_src_in = (i == 0) ? PRVL_SRC_RESET :
                   (i == 1) ? PRVL_SRC_UNUSED : PRVL_SRC_NONE;
      irq_req_in = 1'b1;
      wait_pulse(n, fa);
      chk(16'(n), 16'h0000);
      chk(16'(fa), 16'h1fff);
    end
    for (int k = 0; k < 3; k++) begin
      lookup(6'h10, k);
      lookup(6'h3f, k);
    end
    repeat (40) lookup(6'($urandom_range(63, 16)), $urandom_range(2, 0));
    for (int i = 0; i < 4; i++) begin
      ref_index_in = (i == 0) ? 6'h0f : 6'($urandom_range(14, 0));
      ref_req_in = 1'b1;
      wait_pulse(n, fa);
      chk(16'(n), 16'h0001);
      chk(16'(rerr), 16'h0001);
      chk(16'(fa), 16'h1fff);
    end
    foreach (srcs[i]) vec(srcs[i], 1'b0);
    final_report;
  end

  // Watchdog well beyond the fewer than 500 cycles the sequence needs.
  initial begin
    #200us;
    error_cnt++;
    final_report;
  end
endmodule // testbench
